//--- rtl/scc_fifo_port.sv
// Channel FIFO data port, command and status registers
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "scc_params.svh"
module scc_fifo_port
	import scc_pkg::*;
(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Host bus
	scc_bus_if.device        bus,
	// Receive engine
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_byte,
	output logic             rx_ready,
	input  wire logic        rx_end,
	output logic             rx_pool_full_irq,
	output logic             rx_message_end_irq,
	// Transmit engine
	output logic             tx_valid,
	output logic [7:0]       tx_byte,
	input  wire logic        tx_ready,
	output logic [15:0]      command_out,
	input  wire logic [15:0] cmd_done,
	output logic [7:0]       imm_char,
	input  wire logic        imm_char_sent,
	// Line and engine status
	input  wire logic        xoff_seen,
	input  wire logic        xon_seen,
	input  wire logic        cts,
	input  wire logic        tx_clk_en,
	input  wire logic        cd,
	input  wire logic        sync_found,
	input  wire logic        rx_bit_en,
	input  wire logic        rx_bit,
	input  wire logic        dpll_lost,
	input  wire logic        dpll_locked,
	input  wire logic        dpll_tx_clock,
	input  wire logic [2:0]  auto_status,
	output logic             sync_found_irq,
	output logic             rx_abort,
	output logic             tx_halt
);
	logic [7:0]  cfg_ff;
	logic [15:0] cmd_ff;
	logic [7:0]  rdata_lo_ff, rdata_hi_ff;
	logic        rvalid_ff;
	logic [7:0]  rx_mem [0:31];
	logic [5:0]  rx_wr_ff, rx_rd_ff, rx_free_ff, rx_left_ff;
	logic        end_pend_ff;
	logic [11:0] msg_cnt_ff, rbc_ff;
	logic [7:0]  tx_mem [0:63];
	logic [6:0]  tx_wr_ff, tx_rd_ff, tx_com_ff, rep_start_ff;
	logic        repeat_ff, tx_fifo_overflow_ff, imm_busy_ff, flow_ff, cts_ff, tx_armed_ff;
	logic        rli_ff, sync_ff, dpll_unlocked_ff;
	logic [3:0]  ones_ff;
	logic [7:0]  imm_ff;
	proto_mode_t mode;
	logic [1:0]  rx_threshold_sel;
	logic        dma_enable, inband_flow_enable, sync_irq_en, dpll_coding;
	logic        rd_acc, wr_acc, fifo_rd, fifo_wr, tx_reset_cmd, release_tx;
	logic        rx_push, tx_pop;
	logic [5:0]  thr, rx_avail, rx_pop_n;
	logic [6:0]  tx_acc, tx_n;
	logic [7:0]  stat_lo, stat_hi;

	assign mode               = proto_mode_t'(cfg_ff[3:2]);
	assign rx_threshold_sel   = cfg_ff[1:0];
	assign dma_enable         = cfg_ff[4];
	assign inband_flow_enable = cfg_ff[5];
	assign sync_irq_en        = cfg_ff[6];
	assign dpll_coding        = cfg_ff[7];
	assign rd_acc  = bus.bus_sel && !bus.bus_wr;
	assign wr_acc  = bus.bus_sel && bus.bus_wr;
	assign fifo_rd = rd_acc && bus.bus_addr == `A_FIFO;
	assign fifo_wr = wr_acc && bus.bus_addr == `A_FIFO;
	assign tx_reset_cmd    = cmd_ff[`B_TX_RESET_CMD];
	assign command_out = cmd_ff;

	// RQ2 RQ3 threshold decode
	always_comb begin
		if (mode == MODE_HDLC) begin
			case (rx_threshold_sel)
				2'd0: thr = 6'd32;
				2'd1: thr = 6'd16;
				2'd2: thr = 6'd4;
				default: thr = 6'd2;
			endcase
		end else begin
			case (rx_threshold_sel)
				2'd0: thr = 6'd1;
				2'd1: thr = 6'd4;
				2'd2: thr = 6'd16;
				default: thr = 6'd32;
			endcase
		end
	end

	// Receive side pointers; rx_free trails rx_rd until released
	assign rx_avail = rx_wr_ff - rx_rd_ff;
	assign rx_ready = (rx_wr_ff - rx_free_ff) != `RX_DEPTH;
	assign rx_push  = rx_valid && rx_ready;
	// RQ4 fixed-address pop, never past the current block
	assign rx_pop_n = !fifo_rd ? 6'd0 :
		(bus.bus_word && rx_left_ff >= 6'd2) ? 6'd2 :
		(rx_left_ff != 6'd0) ? 6'd1 : 6'd0;

	always_ff @(posedge aclk) begin
		if (rx_push)
			rx_mem[rx_wr_ff[4:0]] <= rx_byte;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_wr_ff <= 6'd0;
			rx_rd_ff <= 6'd0;
			rx_free_ff <= 6'd0;
		end else begin
			if (rx_push)
				rx_wr_ff <= rx_wr_ff + 6'd1;
			rx_rd_ff <= rx_rd_ff + rx_pop_n;
			// RQ7 space freed by message complete
			if (cmd_ff[`B_RMC])
				rx_free_ff <= rx_rd_ff;
		end
	end

	// RQ5 RQ6 block events and byte count
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_left_ff <= 6'd0;
			end_pend_ff <= 1'b0;
			msg_cnt_ff <= 12'd0;
			rbc_ff <= 12'd0;
			rx_pool_full_irq <= 1'b0;
			rx_message_end_irq <= 1'b0;
		end else begin
			rx_pool_full_irq <= 1'b0;
			rx_message_end_irq <= 1'b0;
			rx_left_ff <= rx_left_ff - rx_pop_n;
			msg_cnt_ff <= msg_cnt_ff + {11'd0, rx_push};
			if (rx_end) begin
				end_pend_ff <= 1'b1;
				rbc_ff <= msg_cnt_ff + {11'd0, rx_push};
				msg_cnt_ff <= 12'd0;
			end
			if (rx_left_ff == 6'd0 && end_pend_ff) begin
				rx_left_ff <= rx_avail;
				end_pend_ff <= 1'b0;
				rx_message_end_irq <= 1'b1;
			end else if (rx_left_ff == 6'd0 && rx_avail >= thr && !rx_end) begin
				rx_left_ff <= thr;
				rx_pool_full_irq <= 1'b1;
			end
		end
	end

	// RQ8 request drops as the last transfer starts
	assign bus.rx_dma_request = dma_enable && rx_left_ff != 6'd0 &&
		!(fifo_rd && rx_pop_n == rx_left_ff);

	// Transmit side: accessible half is tx_com..tx_wr
	assign tx_acc = tx_wr_ff - tx_com_ff;
	assign tx_n   = bus.bus_word ? 7'd2 : 7'd1;
	assign release_tx = cmd_ff[`B_XF] && tx_com_ff == tx_rd_ff;
	assign tx_valid = tx_com_ff != tx_rd_ff && !tx_halt && !tx_reset_cmd;
	assign tx_byte  = tx_mem[tx_rd_ff[5:0]];
	assign tx_pop   = tx_valid && tx_ready;

	always_ff @(posedge aclk) begin
		if (fifo_wr && tx_acc + tx_n <= `HALF_BYTES) begin
			tx_mem[tx_wr_ff[5:0]] <= bus.bus_wdata[7:0];
			if (bus.bus_word)
				tx_mem[tx_wr_ff[5:0] + 6'd1] <= bus.bus_wdata[15:8];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || tx_reset_cmd) begin
			// RQ23 transmitter reset empties FIFO
			tx_wr_ff <= 7'd0;
			tx_rd_ff <= 7'd0;
			tx_com_ff <= 7'd0;
			rep_start_ff <= 7'd0;
			repeat_ff <= 1'b0;
			tx_fifo_overflow_ff <= 1'b0;
		end else begin
			if (fifo_wr && tx_acc + tx_n <= `HALF_BYTES)
				tx_wr_ff <= tx_wr_ff + tx_n;
			// RQ16 overflow on excess bytes
			if (fifo_wr && tx_acc + tx_n > `HALF_BYTES)
				tx_fifo_overflow_ff <= 1'b1;
			else if (release_tx)
				tx_fifo_overflow_ff <= 1'b0;
			if (release_tx) begin
				tx_com_ff <= tx_wr_ff;
				rep_start_ff <= tx_rd_ff;
				// RQ12 repeat runs until reset
				repeat_ff <= cmd_ff[`B_TX_REPEAT_CMD] && cmd_ff[`B_XME];
			end
			// Repeat wraps instead of draining
			if (tx_pop)
				tx_rd_ff <= (repeat_ff && tx_rd_ff + 7'd1 == tx_com_ff) ?
					rep_start_ff : tx_rd_ff + 7'd1;
		end
	end

	// RQ11 request drops as the last transfer starts
	assign bus.tx_dma_request = dma_enable && tx_acc < `HALF_BYTES &&
		!(fifo_wr && tx_acc + tx_n >= `HALF_BYTES);

	// Writable flag stays low until the first transmitter reset, so status reads zero
	always_ff @(posedge aclk) begin
		if (!aresetn)
			tx_armed_ff <= 1'b0;
		else if (tx_reset_cmd)
			tx_armed_ff <= 1'b1;
	end

	// Command bits: writes OR in, set wins over completion
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd_ff <= 16'h0000;
			cfg_ff <= 8'h00;
		end else begin
			cmd_ff <= (cmd_ff & ~(cmd_done & ~`LOCAL_CMDS) &
				~({16{1'b1}} & `LOCAL_CMDS & {16{!cmd_ff[`B_XF] || release_tx}} &
				{5'h1f, ~cmd_ff[`B_XF], 10'h3ff})) |
				((wr_acc && bus.bus_addr == `A_CMD_LO) ?
					{bus.bus_word ? bus.bus_wdata[15:8] : 8'h00, bus.bus_wdata[7:0]} :
				 (wr_acc && bus.bus_addr == `A_CMD_HI) ?
					{bus.bus_wdata[7:0], 8'h00} : 16'h0000);
			if (wr_acc && bus.bus_addr == `A_CONFIG)
				cfg_ff <= bus.bus_wdata[7:0];
		end
	end

	// RQ13 immediate character accepted only while idle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			imm_busy_ff <= 1'b0;
			imm_ff <= 8'h00;
		end else if (wr_acc && bus.bus_addr == `A_IMM_CHAR && !imm_busy_ff &&
				mode == MODE_ASYNC) begin
			imm_busy_ff <= 1'b1;
			imm_ff <= bus.bus_wdata[7:0];
		end else if (imm_char_sent) begin
			imm_busy_ff <= 1'b0;
		end
	end
	assign imm_char = imm_ff;

	// Line status flags
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flow_ff <= 1'b0;
			cts_ff <= 1'b0;
			ones_ff <= 4'd0;
			rli_ff <= 1'b1;
			sync_ff <= 1'b0;
			dpll_unlocked_ff <= 1'b0;
			sync_found_irq <= 1'b0;
		end else begin
			// RQ15 in-band flow state
			if (xoff_seen && inband_flow_enable && mode == MODE_ASYNC)
				flow_ff <= 1'b1;
			else if (tx_reset_cmd || xon_seen || !inband_flow_enable)
				flow_ff <= 1'b0;
			// RQ17 level held while clock is absent
			if (tx_clk_en)
				cts_ff <= cts;
			// RQ21 more than seven ones
			if (rx_bit_en) begin
				ones_ff <= !rx_bit ? 4'd0 :
					(ones_ff == `ONES_LIMIT) ? ones_ff : ones_ff + 4'd1;
				rli_ff <= rx_bit && ones_ff >= `ONES_LIMIT - 4'd1;
			end
			// RQ20 sync found wins over hunt
			sync_found_irq <= 1'b0;
			if (sync_found && mode == MODE_BISYNC) begin
				sync_ff <= 1'b1;
				sync_found_irq <= sync_irq_en;
			end else if (cmd_ff[`B_HUNT]) begin
				sync_ff <= 1'b0;
			end
			// RQ22 lock status
			if (dpll_lost && dpll_coding)
				dpll_unlocked_ff <= 1'b1;
			else if (dpll_locked || !dpll_coding)
				dpll_unlocked_ff <= 1'b0;
		end
	end
	assign rx_abort = dpll_unlocked_ff;
	// RQ22 transmit stops in DPLL clock modes
	assign tx_halt  = dpll_unlocked_ff && dpll_tx_clock;

	// RQ12 RQ13 RQ14 RQ16 low status byte
	always_comb begin
		stat_lo = {repeat_ff, 1'b0, imm_busy_ff && mode == MODE_ASYNC, |cmd_ff,
			flow_ff && mode == MODE_ASYNC, tx_fifo_overflow_ff,
			tx_armed_ff && tx_acc < `HALF_BYTES && !tx_reset_cmd, cts_ff};
		// RQ18 RQ19 RQ21 high status byte
		stat_hi = {1'b0, mode != MODE_HDLC && rx_wr_ff != rx_rd_ff, cd,
			(mode == MODE_HDLC) ? rli_ff : (mode == MODE_BISYNC) && sync_ff,
			dpll_unlocked_ff, (mode == MODE_HDLC) ? auto_status : 3'b000};
	end

	// Read port; RQ24 status is read only, writes fall through
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rdata_lo_ff <= 8'h00;
			rdata_hi_ff <= 8'h00;
			rvalid_ff <= 1'b0;
		end else begin
			rvalid_ff <= rd_acc;
			if (rd_acc) begin
				rdata_hi_ff <= 8'h00;
				case (bus.bus_addr)
					`A_FIFO: begin
						rdata_lo_ff <= rx_mem[rx_rd_ff[4:0]];
						rdata_hi_ff <= rx_mem[rx_rd_ff[4:0] + 5'd1];
					end
					`A_STAT_LO: begin
						rdata_lo_ff <= stat_lo;
						rdata_hi_ff <= stat_hi;
					end
					`A_STAT_HI: rdata_lo_ff <= stat_hi;
					`A_CMD_LO: begin
						rdata_lo_ff <= cmd_ff[7:0];
						rdata_hi_ff <= cmd_ff[15:8];
					end
					`A_CMD_HI: rdata_lo_ff <= cmd_ff[15:8];
					`A_CONFIG: rdata_lo_ff <= cfg_ff;
					`A_IMM_CHAR: rdata_lo_ff <= imm_ff;
					`A_RBC_LO: begin
						rdata_lo_ff <= rbc_ff[7:0];
						rdata_hi_ff <= {4'h0, rbc_ff[11:8]};
					end
					`A_RBC_HI: rdata_lo_ff <= {4'h0, rbc_ff[11:8]};
					default: rdata_lo_ff <= 8'h00;
				endcase
			end
		end
	end
	assign bus.bus_rdata  = {rdata_hi_ff, rdata_lo_ff};
	assign bus.bus_rvalid = rvalid_ff;
endmodule // scc_fifo_port
`default_nettype wire

//--- rtl/scc_params.svh
// Constants for the channel FIFO port, status and the host sequencer
// How it works
// RQ1: 16-bit bus: rx FIFO read by words only; the host also passes a byte read marked last of a frame
// RQ2: HDLC thresholds 32/16/4/2, default 32
// RQ3: Async/bisync thresholds 1/4/16/32, default 1
// RQ4: Up to 32 rx bytes, fixed address
// RQ5: Threshold interrupt; host reads that many bytes
// RQ6: Message end interrupt and byte count
// RQ7: Message complete command frees rx space
// RQ8: Rx DMA request until last transfer starts
// RQ9: 16-bit bus: tx FIFO written by words; the host also passes a byte write marked last of a frame
// RQ10: Up to 32 tx bytes, then transmit
// RQ11: Tx DMA request until last transfer starts
// RQ12: Status bit 7 shows repeat running
// RQ13: Immediate char busy; no rewrite while set
// RQ14: Command busy; no command write while set
// RQ15: XOFF sets flow state, XON/reset clear
// RQ16: Overflow past 32 bytes, cleared on move
// RQ17: Clear-to-send sampled with transmit clock
// RQ18: Rx not empty in async/bisync
// RQ19: Raw carrier detect level
// RQ20: Hunt clears sync, sync char sets it
// RQ21: Line idle after more than 7 ones
// RQ22: DPLL unlock aborts rx, may halt tx
// RQ23: Transmitter reset clears tx FIFO
// RQ24: Status writes are ignored
`ifndef SCC_PARAMS_SVH
`define SCC_PARAMS_SVH
`define A_FIFO      8'h10
`define A_STAT_LO   8'h12
`define A_STAT_HI   8'h13
`define A_CMD_LO    8'h14
`define A_CMD_HI    8'h15
`define A_CONFIG    8'h16
`define A_IMM_CHAR  8'h18
`define A_RBC_LO    8'h1a
`define A_RBC_HI    8'h1b
`define STAT_HI_RST 8'h10
`define HALF_BYTES  7'd32
`define RX_DEPTH    6'd32
`define B_TX_RESET_CMD      4
`define B_XF        3
`define B_XME       2
`define B_TX_REPEAT_CMD      1
`define B_RMC       15
`define B_HUNT      11
`define LOCAL_CMDS  16'h881e
`define ONES_LIMIT  4'd8
`define H_CTRL      4'h0
`define H_STAT      4'h4
`endif

//--- rtl/scc_pkg.sv
// Types shared by both ends of the channel port
package scc_pkg;
	typedef enum logic [1:0] {
		MODE_HDLC,
		MODE_ASYNC,
		MODE_BISYNC,
		MODE_RSVD
	} proto_mode_t;
	typedef enum {
		H_IDLE,
		H_CHECK,
		H_CHECK_WAIT,
		H_ACCESS,
		H_WAIT
	} host_state_t;
endpackage

//--- rtl/scc_bus_if.sv
// Parallel host bus and DMA request lines between host and channel
`timescale 1ns/100ps
`default_nettype none
interface scc_bus_if;
	logic        bus_sel;
	logic        bus_wr;
	logic        bus_word;
	logic        bus_wide;
	logic [7:0]  bus_addr;
	logic [15:0] bus_wdata;
	logic [15:0] bus_rdata;
	logic        bus_rvalid;
	logic        rx_dma_request;
	logic        tx_dma_request;
	modport device (
		input  bus_sel, bus_wr, bus_word, bus_wide, bus_addr, bus_wdata,
		output bus_rdata, bus_rvalid, rx_dma_request, tx_dma_request
	);
	modport host (
		output bus_sel, bus_wr, bus_word, bus_wide, bus_addr, bus_wdata,
		input  bus_rdata, bus_rvalid, rx_dma_request, tx_dma_request
	);
endinterface
`default_nettype wire

//--- rtl/scc_host_port.sv
// Host end: AXI4-Lite command registers driving the channel bus
`timescale 1ns/100ps
`default_nettype none
`include "scc_params.svh"
module scc_host_port
	import scc_pkg::*;
(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite slave
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Bus width strap
	input  wire logic        wide_bus,
	// Channel bus
	scc_bus_if.host          bus
);
	host_state_t st_ff;
	logic [31:0] ctrl_ff;
	logic [15:0] rdata_ff;
	logic        refused_ff;
	logic [6:0]  rx_cnt_ff, tx_cnt_ff;
	logic        do_wr, busy, go, is_fifo, is_cmd, is_imm, bad_width, over;
	logic [6:0]  n;

	assign do_wr = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_awready = do_wr;
	assign s_axi_wready  = do_wr;
	assign busy = st_ff != H_IDLE;
	assign go = do_wr && s_axi_awaddr == `H_CTRL && s_axi_wstrb == 4'hf && !busy;
	assign is_fifo = ctrl_ff[7:0] == `A_FIFO;
	assign is_cmd  = {ctrl_ff[7:1], 1'b0} == `A_CMD_LO;
	assign is_imm  = ctrl_ff[7:0] == `A_IMM_CHAR;
	assign n = ctrl_ff[9] ? 7'd2 : 7'd1;
	// RQ1 RQ9 on a 16-bit bus, byte FIFO access only as the last of a frame
	assign bad_width = is_fifo && wide_bus && !ctrl_ff[9] && !ctrl_ff[10];
	// RQ4 RQ10 at most 32 bytes per block
	assign over = is_fifo && ((ctrl_ff[8] ? tx_cnt_ff : rx_cnt_ff) + n > `HALF_BYTES);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end else if (do_wr) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (s_axi_awaddr == `H_CTRL) ? 2'b00 : 2'b10;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'b00;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'b00;
			case (s_axi_araddr)
				`H_CTRL: s_axi_rdata <= ctrl_ff;
				`H_STAT: s_axi_rdata <= {rdata_ff, 14'h0000, refused_ff, busy};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= 2'b10;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Sequencer; command and immediate writes poll status first
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff <= H_IDLE;
			ctrl_ff <= 32'h0000_0000;
			rdata_ff <= 16'h0000;
			refused_ff <= 1'b0;
		end else begin
			case (st_ff)
				H_IDLE: if (go) begin
					ctrl_ff <= s_axi_wdata;
					refused_ff <= 1'b0;
					st_ff <= H_CHECK;
				end
				H_CHECK: begin
					if (bad_width || over) begin
						refused_ff <= 1'b1;
						st_ff <= H_IDLE;
					end else if ((is_cmd || is_imm) && ctrl_ff[8])
						st_ff <= H_CHECK_WAIT;
					else
						st_ff <= H_ACCESS;
				end
				H_CHECK_WAIT: if (bus.bus_rvalid) begin
					// RQ13 RQ14 hold off while busy bits set
					if ((is_cmd && bus.bus_rdata[4]) || (is_imm && bus.bus_rdata[5])) begin
						refused_ff <= 1'b1;
						st_ff <= H_IDLE;
					end else
						st_ff <= H_ACCESS;
				end
				H_ACCESS: st_ff <= ctrl_ff[8] ? H_IDLE : H_WAIT;
				H_WAIT: if (bus.bus_rvalid) begin
					rdata_ff <= bus.bus_rdata;
					st_ff <= H_IDLE;
				end
				default: st_ff <= H_IDLE;
			endcase
		end
	end

	// RQ7 RQ10 block counters restart on complete or transmit command
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_cnt_ff <= 7'd0;
			tx_cnt_ff <= 7'd0;
		end else if (st_ff == H_ACCESS) begin
			if (is_fifo && ctrl_ff[8])
				tx_cnt_ff <= tx_cnt_ff + n;
			else if (is_fifo)
				rx_cnt_ff <= rx_cnt_ff + n;
			if (ctrl_ff[7:0] == `A_CMD_HI && ctrl_ff[8] && ctrl_ff[23])
				rx_cnt_ff <= 7'd0;
			if (ctrl_ff[7:0] == `A_CMD_LO && ctrl_ff[8] && (ctrl_ff[19] || ctrl_ff[20]))
				tx_cnt_ff <= 7'd0;
		end
	end

	always_comb begin
		bus.bus_sel   = st_ff == H_ACCESS ||
			(st_ff == H_CHECK && (is_cmd || is_imm) && ctrl_ff[8] && !bad_width && !over);
		bus.bus_wr    = st_ff == H_ACCESS && ctrl_ff[8];
		bus.bus_word  = st_ff == H_ACCESS && ctrl_ff[9];
		bus.bus_wide  = wide_bus;
		bus.bus_addr  = (st_ff == H_ACCESS) ? ctrl_ff[7:0] : `A_STAT_LO;
		bus.bus_wdata = ctrl_ff[31:16];
	end
endmodule // scc_host_port
`default_nettype wire

//--- dv/scc_port_checker.sv
// Concurrent checks on the channel bus between the host end and the device end
`timescale 1ns/100ps
`default_nettype none
module scc_port_checker (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Channel bus
	input wire logic        bus_sel,
	input wire logic        bus_wr,
	input wire logic        bus_word,
	input wire logic [7:0]  bus_addr,
	input wire logic [15:0] bus_rdata,
	input wire logic        bus_rvalid,
	input wire logic        rx_dma_request,
	input wire logic        tx_dma_request
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// Read strobe seen one cycle back; cleared in reset so no stale cause
	logic rd_ff;
	always_ff @(posedge aclk) begin
		rd_ff <= aresetn && bus_sel && !bus_wr;
	end

	sequence rd_req;
		bus_sel && !bus_wr;
	endsequence
	sequence fifo_rd;
		bus_sel && !bus_wr && bus_addr == 8'h10;
	endsequence
	sequence stat_rd;
		bus_sel && !bus_wr && bus_word && bus_addr == 8'h12;
	endsequence

	chk_read_answer: assert property (rd_req |=> bus_rvalid)
		else $error("read strobe not answered next cycle");
	chk_rvalid_cause: assert property (bus_rvalid |-> rd_ff)
		else $error("read answer without a read strobe");
	chk_write_silent: assert property (bus_sel && bus_wr |=> !bus_rvalid)
		else $error("write strobe produced a read answer");
	chk_strobe_pulse: assert property (bus_sel |=> !bus_sel)
		else $error("access strobe longer than one cycle");
	chk_no_overlap: assert property (bus_rvalid |-> !bus_sel)
		else $error("new access while an answer is pending");
	chk_status_zeros: assert property (stat_rd |=> bus_rvalid && !bus_rdata[6] && !bus_rdata[15])
		else $error("reserved status bits not zero");
	chk_rx_dma_drop: assert property ($fell(rx_dma_request) |-> fifo_rd)
		else $error("receive request dropped without a fifo read");
	chk_tx_dma_drop: assert property ($fell(tx_dma_request) |-> bus_sel && bus_wr && bus_addr == 8'h10)
		else $error("transmit request dropped without a fifo write");
endmodule // scc_port_checker
`default_nettype wire

//--- dv/scc_fifo_port_and_status_tb.sv
// Bench: host end and device end joined on the channel bus, driven over AXI4-Lite
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
	$display("Error %0t: got %h want %h", $time, (a), (b)); end end
module scc_fifo_port_and_status_tb
	import scc_pkg::*;
;
	logic aclk = 1'b0, aresetn = 1'b0, rx_valid = 0, rx_end = 0, tx_ready = 0, cd = 0, cts = 0;
	logic imm_char_sent = 0, xoff_seen = 0, xon_seen = 0, tx_clk_en = 0, sync_found = 0;
	logic rx_bit_en = 0, rx_bit = 0, dpll_lost = 0, dpll_locked = 0, dpll_tx_clock = 0;
	logic wide_bus = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic [7:0] rx_byte = 8'h00, tx_byte, imm_char, b;
	logic [15:0] cmd_done = 16'h0000, command_out, s;
	logic [2:0] auto_status = 3'h0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_wstrb = 4'hf, s_axi_araddr = 4'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, st;
	logic rx_ready, rx_pool_full_irq, rx_message_end_irq, tx_valid, sync_found_irq, rx_abort;
	logic tx_halt, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int n_mismatch = 0, compares = 0, n_pf = 0, n_me = 0;

	scc_bus_if bus_if ();
	scc_fifo_port u_scc_fifo_port (.aclk, .aresetn, .bus(bus_if), .rx_valid, .rx_byte, .rx_ready,
		.rx_end, .rx_pool_full_irq, .rx_message_end_irq, .tx_valid, .tx_byte, .tx_ready,
		.command_out, .cmd_done, .imm_char, .imm_char_sent, .xoff_seen, .xon_seen, .cts,
		.tx_clk_en, .cd, .sync_found, .rx_bit_en, .rx_bit, .dpll_lost, .dpll_locked,
		.dpll_tx_clock, .auto_status, .sync_found_irq, .rx_abort, .tx_halt);
	scc_host_port u_scc_host_port (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wide_bus, .bus(bus_if));
	scc_port_checker u_chk (.aclk, .aresetn, .bus_sel(bus_if.bus_sel), .bus_wr(bus_if.bus_wr),
		.bus_word(bus_if.bus_word), .bus_addr(bus_if.bus_addr), .bus_rdata(bus_if.bus_rdata),
		.bus_rvalid(bus_if.bus_rvalid), .rx_dma_request(bus_if.rx_dma_request),
		.tx_dma_request(bus_if.tx_dma_request));

	always #4 aclk = ~aclk;
	always @(posedge aclk) begin
		n_pf += (rx_pool_full_irq === 1'b1);
		n_me += (rx_message_end_irq === 1'b1);
	end

	task automatic report_and_stop;
		if (n_mismatch == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic tmo(input int n);
		if (n > 200) begin
			n_mismatch++;
			report_and_stop;
		end
	endtask
	task automatic axw(input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			tmo(n);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
	endtask
	task automatic axr(input logic [3:0] a);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			tmo(n);
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		st = s_axi_rdata;
		s_axi_rready <= 1'b0;
	endtask
	// One device access through the host registers; result left in st and s
	task automatic dev(input logic w, input logic [7:0] a, input logic [15:0] d, input logic wd);
		int n;
		n = 0;
		axw(4'h0, {d, 5'h00, 1'b0, wd, w, a});
		do begin
			axr(4'h4);
			n++;
			tmo(n * 10);
		end while (st[0] !== 1'b0);
		s = st[31:16];
	endtask
	task automatic stat;
		dev(1'b0, 8'h12, 16'h0000, 1'b1);
	endtask
	task automatic push(input logic [7:0] d, input logic e);
		int n;
		n = 0;
		@(posedge aclk);
		rx_valid <= 1'b1;
		rx_byte <= d;
		rx_end <= e;
		do begin
			@(posedge aclk);
			n++;
			tmo(n);
		end while (rx_ready !== 1'b1);
		rx_valid <= 1'b0;
		rx_end <= 1'b0;
	endtask
	task automatic wpf(input int x);
		int n;
		n = 0;
		while (n_pf < x) begin
			@(posedge aclk);
			n++;
			tmo(n);
		end
	endtask

	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		stat;
		`CHK(s, 16'h1000)
		dev(1'b1, 8'h12, 16'h00ff, 1'b0);
		dev(1'b1, 8'h13, 16'h00ff, 1'b0);
		stat;
		`CHK(s, 16'h1000)
		cd <= 1'b1;
		cts <= 1'b1;
		stat;
		`CHK(s[13], 1'b1)
		`CHK(s[0], 1'b0)
		tx_clk_en <= 1'b1;
		stat;
		`CHK(s[0], 1'b1)
		// Short message, then a full 16 byte block
		dev(1'b1, 8'h16, 16'h0001, 1'b0);
		push(8'h11, 1'b0);
		push(8'h12, 1'b0);
		push(8'h13, 1'b1);
		dev(1'b0, 8'h1a, 16'h0000, 1'b0);
		`CHK(s[7:0], 8'h03)
		`CHK(n_me, 1)
		`CHK(n_pf, 0)
		for (int i = 0; i < 3; i++) begin
			dev(1'b0, 8'h10, 16'h0000, 1'b0);
			`CHK(s[7:0], 8'h11 + i[7:0])
		end
		dev(1'b1, 8'h15, 16'h0080, 1'b0);
		for (int i = 0; i < 16; i++) begin
			push(8'h20 + i[7:0], 1'b0);
			if (i == 14) begin
				stat;
				`CHK(n_pf, 0)
			end
		end
		wpf(1);
		for (int i = 0; i < 16; i++) begin
			dev(1'b0, 8'h10, 16'h0000, 1'b0);
			`CHK(s[7:0], 8'h20 + i[7:0])
		end
		dev(1'b1, 8'h15, 16'h0080, 1'b0);
		// Async, threshold of one byte
		dev(1'b1, 8'h16, 16'h0004, 1'b0);
		push(8'h5a, 1'b0);
		wpf(2);
		stat;
		`CHK(s[14], 1'b1)
		dev(1'b0, 8'h10, 16'h0000, 1'b0);
		`CHK(s[7:0], 8'h5a)
		dev(1'b1, 8'h15, 16'h0080, 1'b0);
		stat;
		`CHK(s[14], 1'b0)
		dev(1'b1, 8'h18, 16'h0041, 1'b0);
		stat;
		`CHK(s[5], 1'b1)
		dev(1'b1, 8'h18, 16'h0042, 1'b0);
		`CHK(st[1], 1'b1)
		`CHK(imm_char, 8'h41)
		@(posedge aclk) imm_char_sent <= 1'b1;
		@(posedge aclk) imm_char_sent <= 1'b0;
		stat;
		`CHK(s[5], 1'b0)
		dev(1'b1, 8'h16, 16'h0024, 1'b0);
		@(posedge aclk) xoff_seen <= 1'b1;
		@(posedge aclk) xoff_seen <= 1'b0;
		stat;
		`CHK(s[3], 1'b1)
		@(posedge aclk) xon_seen <= 1'b1;
		@(posedge aclk) xon_seen <= 1'b0;
		stat;
		`CHK(s[3], 1'b0)
		// Engine-executed command keeps the busy bit until done
		dev(1'b1, 8'h14, 16'h0080, 1'b0);
		stat;
		`CHK(s[4], 1'b1)
		`CHK(command_out[7], 1'b1)
		dev(1'b1, 8'h14, 16'h0040, 1'b0);
		`CHK(st[1], 1'b1)
		@(posedge aclk) cmd_done <= 16'h0080;
		@(posedge aclk) cmd_done <= 16'h0000;
		stat;
		`CHK(s[4], 1'b0)
		// Second transmit stays pending, so the host count restarts and the FIFO overflows
		for (int i = 0; i < 65; i++) begin
			if (i == 32 || i == 64)
				dev(1'b1, 8'h14, 16'h0008, 1'b0);
			dev(1'b1, 8'h10, {8'h00, i[7:0]}, 1'b0);
			stat;
			`CHK(s[2], (i == 64))
		end
		tx_ready <= 1'b1;
		repeat (40) @(posedge aclk);
		tx_ready <= 1'b0;
		stat;
		`CHK(s[2], 1'b0)
		`CHK(tx_valid, 1'b1)
		dev(1'b1, 8'h14, 16'h0010, 1'b0);
		stat;
		`CHK(s[2:1], 2'b01)
		`CHK(tx_valid, 1'b0)
		dev(1'b1, 8'h16, 16'h0008, 1'b0);
		dev(1'b1, 8'h15, 16'h0008, 1'b0);
		stat;
		`CHK(s[12], 1'b0)
		@(posedge aclk) sync_found <= 1'b1;
		@(posedge aclk) sync_found <= 1'b0;
		stat;
		`CHK(s[12], 1'b1)
		dev(1'b1, 8'h16, 16'h0080, 1'b0);
		@(posedge aclk) dpll_lost <= 1'b1;
		@(posedge aclk) dpll_lost <= 1'b0;
		stat;
		`CHK(s[11], 1'b1)
		`CHK(rx_abort, 1'b1)
		@(posedge aclk) dpll_locked <= 1'b1;
		@(posedge aclk) dpll_locked <= 1'b0;
		stat;
		`CHK(s[11], 1'b0)
		rx_bit_en <= 1'b1;
		stat;
		`CHK(s[12], 1'b0)
		rx_bit <= 1'b1;
		repeat (9) @(posedge aclk);
		stat;
		`CHK(s[12], 1'b1)
		// DMA requests on both directions
		dev(1'b1, 8'h16, 16'h0014, 1'b0);
		`CHK(bus_if.tx_dma_request, 1'b1)
		push(8'h66, 1'b0);
		stat;
		`CHK(bus_if.rx_dma_request, 1'b1)
		dev(1'b0, 8'h10, 16'h0000, 1'b0);
		`CHK(s[7:0], 8'h66)
		`CHK(bus_if.rx_dma_request, 1'b0)
		wide_bus <= 1'b1;
		dev(1'b0, 8'h10, 16'h0000, 1'b0);
		`CHK(st[1], 1'b1)
		dev(1'b1, 8'h10, 16'h0000, 1'b0);
		`CHK(st[1], 1'b1)
		for (int i = 0; i < 16; i++)
			dev(1'b1, 8'h10, 16'h0000, 1'b1);
		`CHK(bus_if.tx_dma_request, 1'b0)
		report_and_stop;
	end
endmodule // scc_fifo_port_and_status_tb
`default_nettype wire
